/* File: sim/dio_map_asserts.sv */
// Port-level checks for the trigger/alarm event mapper.
// Assumes one clock domain and an APB master that holds each request.
`default_nettype none

module dio_map_asserts #(
    parameter LINES = 8,
    parameter CHANS = 3,
    parameter RW    = 16
) (
    input wire logic                  clk_i,
    input wire logic                  rstn_i,
    input wire logic                  psel_i,
    input wire logic                  penable_i,
    input wire logic                  pwrite_i,
    input wire logic [31:0]           prdata_o,
    input wire logic                  pready_o,
    input wire logic                  pslverr_o,
    input wire logic                  irq_o,
    input wire logic [LINES-1:0]      trigger_input_line_i,
    input wire logic [LINES-1:0]      alarm_line_o,
    input wire logic [9:0]            fault_i,
    input wire logic                  usb_present_i,
    input wire logic                  background_active_i,
    input wire logic [CHANS*RW-1:0]   reading_i,
    input wire logic [1:0]            cal_state_o,
    input wire logic [CHANS-1:0]      over_range_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    // ----------------------------------------
    // Cycles since the last possible cause
    // ----------------------------------------
    // Outputs may only move shortly after an input change or a committed write
    logic [CHANS*RW+LINES+CHANS+13:0] stim;
    logic [CHANS*RW+LINES+CHANS+13:0] stim_q;
    logic [2:0]                       quiet;
    assign stim = {trigger_input_line_i, fault_i, usb_present_i, background_active_i,
                   reading_i, cal_state_o, over_range_o};

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stim_q <= '0;
            quiet  <= 3'h0;
        end else begin
            stim_q <= stim;
            if (stim != stim_q || (psel_i && penable_i && pready_o && pwrite_i))
                quiet <= 3'h0;
            else if (quiet != 3'h7)
                quiet <= quiet + 3'h1;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_ready_wait:
        assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("pready missing after first access cycle");
    a_ready_single:
        assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    a_ready_held:
        assert property (pready_o |-> psel_i && penable_i)
        else $error("pready outside an access phase");
    a_err_no_data:
        assert property (pready_o && pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
        else $error("refused read returned data");
    a_cal_cause:
        assert property ($changed(cal_state_o) |-> quiet <= 3'h3)
        else $error("calibration state moved with no cause");
    a_alarm_cause:
        assert property ($changed(alarm_line_o) |-> quiet <= 3'h5)
        else $error("alarm line moved with no cause");
    a_ovr_cause:
        assert property ($changed(over_range_o) |-> quiet <= 3'h1)
        else $error("over-range moved with no cause");
    a_irq_cause:
        assert property ($rose(irq_o) |-> quiet <= 3'h3)
        else $error("interrupt rose with no cause");
endmodule

bind digital_io_event_mapper dio_map_asserts #(
    .LINES(LINES),
    .CHANS(CHANS),
    .RW(RW)
) u_dio_map_asserts (
    .clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .prdata_o, .pready_o, .pslverr_o,
    .irq_o, .trigger_input_line_i, .alarm_line_o, .fault_i, .usb_present_i,
    .background_active_i, .reading_i, .cal_state_o, .over_range_o
);

`default_nettype wire

/* File: sim/logger_model.sv */
// Data logger that drives the trigger lines of the mapper.
// Assumes the bench calls drive() from its main sequence.
`default_nettype none

module logger_model (
    // Clock
    input  wire logic      clk_i,
    // Trigger lines towards the device
    output var logic [7:0] line_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Line 0 rests low, the others high: no request pending at start
    initial line_o = 8'hfe;

    task automatic drive(input int n, input logic lvl, input int hold);
        @(posedge clk_i);
        line_o[n] <= lvl;
        repeat (hold) @(posedge clk_i);
    endtask
endmodule

`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench for the event mapper: APB master, logger, alarm table.
// Assumes the register map and codes of the shared header.
`include "dio_map_regs.vh"
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [4:0] code;
        logic       pol;
        logic [9:0] flt;
        logic       usb;
        logic       bg;
        logic       exp;
    } row_t;
    logic        clk_i = 1'h0;
    logic        rstn_i = 1'h0;
    logic        psel_i = 1'h0;
    logic        penable_i = 1'h0;
    logic        pwrite_i = 1'h0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [9:0]  fault_i = 10'h000;
    logic        usb_present_i = 1'h1;
    logic        background_active_i = 1'h0;
    logic [47:0] reading_i = 48'h0;
    wire  [31:0] prdata_o;
    wire         pready_o;
    wire         pslverr_o;
    wire         irq_o;
    wire  [7:0]  trig;
    wire  [7:0]  alarm_line_o;
    wire  [1:0]  cal_state_o;
    wire  [2:0]  over_range_o;
    logic [31:0] rdata;
    logic        rerr;
    logic [63:0] s;
    int          ln;
    int          num_errors = 0;
    int          samples_checked = 0;
    logic [15:0] rv [4] = '{16'h0059, 16'h005a, 16'h0051, 16'h0050};
    row_t        rows [19] = '{
        '{5'h01, 1'h1, 10'h001, 1'h1, 1'h0, 1'h1}, '{5'h02, 1'h0, 10'h002, 1'h1, 1'h0, 1'h0},
        '{5'h03, 1'h1, 10'h3fb, 1'h1, 1'h0, 1'h0}, '{5'h04, 1'h1, 10'h008, 1'h1, 1'h0, 1'h1},
        '{5'h05, 1'h1, 10'h3ff, 1'h1, 1'h0, 1'h0}, '{5'h06, 1'h1, 10'h010, 1'h1, 1'h0, 1'h1},
        '{5'h07, 1'h0, 10'h020, 1'h1, 1'h0, 1'h0}, '{5'h08, 1'h1, 10'h040, 1'h1, 1'h0, 1'h1},
        '{5'h09, 1'h1, 10'h080, 1'h1, 1'h0, 1'h1}, '{5'h0a, 1'h0, 10'h3ff, 1'h1, 1'h0, 1'h1},
        '{5'h0b, 1'h1, 10'h100, 1'h1, 1'h0, 1'h1}, '{5'h0c, 1'h1, 10'h200, 1'h1, 1'h0, 1'h1},
        '{5'h0d, 1'h1, 10'h000, 1'h0, 1'h0, 1'h1}, '{5'h0d, 1'h1, 10'h000, 1'h1, 1'h0, 1'h0},
        '{5'h0e, 1'h0, 10'h000, 1'h1, 1'h1, 1'h0}, '{5'h11, 1'h1, 10'h040, 1'h1, 1'h0, 1'h1},
        '{5'h11, 1'h1, 10'h000, 1'h1, 1'h0, 1'h0}, '{5'h00, 1'h1, 10'h3ff, 1'h0, 1'h1, 1'h0},
        '{5'h16, 1'h1, 10'h3ff, 1'h0, 1'h1, 1'h0}};

    always #12.5 clk_i = ~clk_i;

    digital_io_event_mapper u_digital_io_event_mapper (
        .clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
        .pready_o, .pslverr_o, .irq_o, .trigger_input_line_i(trig), .alarm_line_o,
        .fault_i, .usb_present_i, .background_active_i, .reading_i, .cal_state_o,
        .over_range_o);
    logger_model u_logger_model (.clk_i(clk_i), .line_o(trig));

    // ----------------------------------------
    // Bus, compare and closing tasks
    // ----------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'h1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'h1;
        // Wait for the slave; only the watchdog ends a hang
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'h1);
        rdata = prdata_o;
        rerr = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(rdata, exp);
    endtask

    task automatic end_sim();
        $display("errors=%0d checks=%0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #1ms;
        num_errors++;
        end_sim();
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        // Inactive alarm level is high with reset polarity
        chk({19'h0, cal_state_o, irq_o, alarm_line_o, over_range_o}, 32'h7f8);
        rd(`TRIG_CFG_OFS, 32'h0);
        rd(`OVR_SPAN0_OFS, 32'h0000ffff);
        apb(1'h0, 8'h40, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        chk(rdata, 32'h0);
        // Alarm table: rows cycle over the eight lines, the other lines disabled
        foreach (rows[i]) begin
            ln = i % 8;
            s = 64'(rows[i].code) << (8 * ln);
            fault_i <= rows[i].flt;
            usb_present_i <= rows[i].usb;
            background_active_i <= rows[i].bg;
            apb(1'h1, `ALARM_SEL0_OFS, s[31:0]);
            apb(1'h1, `ALARM_SEL1_OFS, s[63:32]);
            apb(1'h1, `ALARM_POL_OFS, {24'h0, 8'(rows[i].pol) << ln});
            repeat (3) @(posedge clk_i);
            chk({24'h0, alarm_line_o}, {24'h0, ~(8'h01 << ln) | (8'(rows[i].exp) << ln)});
        end
        fault_i <= 10'h000;
        usb_present_i <= 1'h1;
        background_active_i <= 1'h0;
        // Triggers: line 0 span high, line 1 zero low, line 2 disabled
        apb(1'h1, `IRQ_EN_OFS, 32'h1f);
        apb(1'h1, `TRIG_CFG_OFS, 32'h0005_0009);
        rd(`TRIG_CFG_OFS, 32'h0001_0009);
        u_logger_model.drive(0, 1'h1, 5);
        chk({29'h0, irq_o, cal_state_o}, 32'h5);
        apb(1'h1, `IRQ_CLR_OFS, 32'h1);
        repeat (4) @(posedge clk_i);
        rd(`IRQ_STAT_OFS, 32'h0);
        u_logger_model.drive(1, 1'h0, 5);
        chk({30'h0, cal_state_o}, 32'h2);
        u_logger_model.drive(2, 1'h0, 5);
        u_logger_model.drive(2, 1'h1, 5);
        chk({30'h0, cal_state_o}, 32'h2);
        apb(1'h1, `IRQ_EN_OFS, 32'h0);
        @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h0);
        rd(`IRQ_STAT_OFS, 32'h2);
        u_logger_model.drive(0, 1'h0, 2);
        u_logger_model.drive(0, 1'h1, 5);
        chk({30'h0, cal_state_o}, 32'h1);
        apb(1'h1, `IRQ_CLR_OFS, 32'h1f);
        apb(1'h1, `ALARM_SEL0_OFS, 32'h0f);
        apb(1'h1, `ALARM_POL_OFS, 32'h1);
        repeat (3) @(posedge clk_i);
        chk({31'h0, alarm_line_o[0]}, 32'h1);
        apb(1'h1, `OVR_CFG_OFS, 32'h8);
        apb(1'h1, `ALARM_SEL0_OFS, 32'h12);
        repeat (3) @(posedge clk_i);
        chk({31'h0, alarm_line_o[0]}, 32'h1);
        // Over-range of channel 0 against a span of 100
        apb(1'h1, `ALARM_SEL0_OFS, 32'h13);
        apb(1'h1, `OVR_SPAN0_OFS, 32'h64);
        apb(1'h1, `OVR_CFG_OFS, 32'h1);
        for (int k = 0; k < 4; k++) begin
            reading_i <= {32'h0, rv[k]};
            repeat (4) @(posedge clk_i);
            chk({30'h0, over_range_o[0], alarm_line_o[0]}, {30'h0, {2{k == 1 || k == 2}}});
        end
        rd(`IRQ_STAT_OFS, 32'h4);
        // Software calibration write and the condition word it shows
        apb(1'h1, `CAL_MODE_OFS, 32'h2);
        rd(`CAL_MODE_OFS, 32'h2);
        rd(`COND_OFS, 32'h0001_0000);
        // Mid-run reset returns the calibration, interrupt, alarm and over-range outputs and the over-range and trigger settings to reset
        rstn_i <= 1'h0;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        chk({19'h0, cal_state_o, irq_o, alarm_line_o, over_range_o}, 32'h7f8);
        rd(`OVR_CFG_OFS, 32'h0);
        rd(`TRIG_CFG_OFS, 32'h0);
        end_sim();
    end
endmodule

`default_nettype wire

/* File: src/digital_io_event_mapper.v */
// Trigger-input to calibration-request mapper and alarm-output selector,
// with over-range tracking for three analog channels and an APB slave.
// Assumes fault, reading and status inputs come from logic on clk_i;
// the trigger lines are asynchronous pins.
//
// Local design decisions: register access over APB and the address map.
`include "dio_map_regs.vh"
`default_nettype none

module digital_io_event_mapper #(
    parameter LINES = 8,
    parameter CHANS = 3,
    parameter RW    = 16
) (
    // Clock and reset
    input  wire                  clk_i,
    input  wire                  rstn_i,
    // APB slave
    input  wire                  psel_i,
    input  wire                  penable_i,
    input  wire                  pwrite_i,
    input  wire [7:0]            paddr_i,
    input  wire [31:0]           pwdata_i,
    output reg  [31:0]           prdata_o,
    output reg                   pready_o,
    output reg                   pslverr_o,
    output wire                  irq_o,
    // Trigger pins and alarm pins
    input  wire [LINES-1:0]      trigger_input_line_i,
    output reg  [LINES-1:0]      alarm_line_o,
    // Instrument conditions
    input  wire [9:0]            fault_i,
    input  wire                  usb_present_i,
    input  wire                  background_active_i,
    input  wire [CHANS*RW-1:0]   reading_i,
    // Calibration state and over-range flags
    output reg  [1:0]            cal_state_o,
    output wire [CHANS-1:0]      over_range_o
);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg  [2*LINES-1:0]   trig_act;
    reg  [LINES-1:0]     trig_pol;
    reg  [4:0]           alarm_sel [0:LINES-1];
    reg  [LINES-1:0]     alarm_pol;
    reg  [CHANS-1:0]     ovr_en;
    reg                  maint_mode;
    reg  [RW-1:0]        ovr_span [0:CHANS-1];
    reg  [4:0]           irq_stat;
    reg  [4:0]           irq_en;

    // Reset image of the whole trigger word, actions and polarities
    localparam [31:0]    TRIG_RST = `TRIG_CFG_RST;

    // ----------------------------------------
    // APB handshake
    // ----------------------------------------
    // One wait state so that read data comes straight from a flop.
    wire                 setup_acc;
    wire                 wr_fire;
    wire                 clr_fire;
    reg  [31:0]          next_rdata;
    reg                  next_err;
    wire [31:0]          cond_word;
    integer              k;

    assign setup_acc = psel_i & penable_i & ~pready_o;
    assign wr_fire   = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
    assign clr_fire  = wr_fire & (paddr_i == `IRQ_CLR_OFS);

    function [LINES-1:0] eff_pol;
        input [2*LINES-1:0] act;
        input [LINES-1:0]   pol;
        integer             j;
        begin
            for (j = 0; j < LINES; j = j + 1) begin
                eff_pol[j] = (act[2*j +: 2] != `ACT_DISABLED) & pol[j];
            end
        end
    endfunction

    always @* begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        k          = 0;
        case (paddr_i)
            `TRIG_CFG_OFS: begin
                next_rdata[2*LINES-1:0] = trig_act;
                next_rdata[`TRIG_POL_LSB +: LINES] = eff_pol(trig_act, trig_pol);
            end
            `ALARM_SEL0_OFS: begin
                for (k = 0; k < 4; k = k + 1) begin
                    next_rdata[8*k +: 5] = alarm_sel[k];
                end
            end
            `ALARM_SEL1_OFS: begin
                for (k = 0; k < 4; k = k + 1) begin
                    next_rdata[8*k +: 5] = alarm_sel[k+4];
                end
            end
            `ALARM_POL_OFS:  next_rdata[LINES-1:0] = alarm_pol;
            `CAL_MODE_OFS:   next_rdata[1:0] = cal_state_o;
            `IRQ_STAT_OFS:   next_rdata[4:0] = irq_stat;
            `IRQ_CLR_OFS:    next_rdata = 32'h0000_0000;
            `IRQ_EN_OFS:     next_rdata[4:0] = irq_en;
            `COND_OFS:       next_rdata = cond_word;
            `OVR_CFG_OFS: begin
                next_rdata[CHANS-1:0] = ovr_en;
                next_rdata[`OVR_MAINT_BIT] = maint_mode;
            end
            `OVR_SPAN0_OFS:  next_rdata[RW-1:0] = ovr_span[0];
            `OVR_SPAN1_OFS:  next_rdata[RW-1:0] = ovr_span[1];
            `OVR_SPAN2_OFS:  next_rdata[RW-1:0] = ovr_span[2];
            default:         next_err = 1'b1;
        endcase
    end

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else if (setup_acc) begin
            pready_o  <= 1'b1;
            pslverr_o <= next_err;
            prdata_o  <= pwrite_i ? 32'h0000_0000 : next_rdata;
        end else begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end
    end

    // ----------------------------------------
    // Configuration writes
    // ----------------------------------------
    integer i;

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trig_act   <= TRIG_RST[2*LINES-1:0];
            trig_pol   <= TRIG_RST[`TRIG_POL_LSB +: LINES];
            alarm_pol  <= `ALARM_POL_RST;
            ovr_en     <= {CHANS{1'b0}};
            maint_mode <= 1'b0;
            irq_en     <= 5'h00;
            for (i = 0; i < LINES; i = i + 1) begin
                alarm_sel[i] <= `COND_DISABLED;
            end
            for (i = 0; i < CHANS; i = i + 1) begin
                ovr_span[i] <= `OVR_SPAN_RST;
            end
        end else if (wr_fire) begin
            case (paddr_i)
                `TRIG_CFG_OFS: begin
                    trig_act <= pwdata_i[2*LINES-1:0];
                    trig_pol <= pwdata_i[`TRIG_POL_LSB +: LINES];
                end
                `ALARM_SEL0_OFS: begin
                    for (i = 0; i < 4; i = i + 1) begin
                        alarm_sel[i] <= pwdata_i[8*i +: 5];
                    end
                end
                `ALARM_SEL1_OFS: begin
                    for (i = 0; i < 4; i = i + 1) begin
                        alarm_sel[i+4] <= pwdata_i[8*i +: 5];
                    end
                end
                `ALARM_POL_OFS:  alarm_pol <= pwdata_i[LINES-1:0];
                `IRQ_EN_OFS:     irq_en <= pwdata_i[4:0];
                `OVR_CFG_OFS: begin
                    ovr_en     <= pwdata_i[CHANS-1:0];
                    maint_mode <= pwdata_i[`OVR_MAINT_BIT];
                end
                `OVR_SPAN0_OFS:  ovr_span[0] <= pwdata_i[RW-1:0];
                `OVR_SPAN1_OFS:  ovr_span[1] <= pwdata_i[RW-1:0];
                `OVR_SPAN2_OFS:  ovr_span[2] <= pwdata_i[RW-1:0];
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // Trigger inputs
    // ----------------------------------------
    reg  [LINES-1:0]     sync_a;
    reg  [LINES-1:0]     sync_b;
    reg  [LINES-1:0]     active_d;
    wire [LINES-1:0]     pol_eff;
    wire [LINES-1:0]     active;
    wire [LINES-1:0]     rise;
    reg                  span_req;
    reg                  zero_req;
    integer              m;

    assign pol_eff = eff_pol(trig_act, trig_pol);
    // Level per polarity
    // Active-high passes the pin, active-low inverts it
    assign active  = ~(sync_b ^ pol_eff);
    assign rise    = active & ~active_d;

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync_a   <= {LINES{1'b1}};
            sync_b   <= {LINES{1'b1}};
            active_d <= {LINES{1'b0}};
        end else begin
            sync_a   <= trigger_input_line_i;
            sync_b   <= sync_a;
            active_d <= active;
        end
    end

    always @* begin
        span_req = 1'b0;
        zero_req = 1'b0;
        m        = 0;
        // A line held at its active level fires once only
        for (m = 0; m < LINES; m = m + 1) begin
            if (rise[m] && trig_act[2*m +: 2] == `ACT_SPAN) begin
                span_req = 1'b1;
            end
            if (rise[m] && trig_act[2*m +: 2] == `ACT_ZERO) begin
                zero_req = 1'b1;
            end
            // Disabled does nothing: code 0 and code 3 match neither
        end
    end

    // ----------------------------------------
    // Calibration state
    // ----------------------------------------
    // Hardware requests win over a software write in the same cycle;
    // span wins when both requests land together.
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cal_state_o <= `CAL_MEASURE;
        end else if (span_req) begin
            cal_state_o <= `CAL_SPAN;
        end else if (zero_req) begin
            cal_state_o <= `CAL_ZERO;
        end else if (wr_fire && paddr_i == `CAL_MODE_OFS) begin
            cal_state_o <= pwdata_i[1:0];
        end
    end

    // ----------------------------------------
    // Over-range tracking
    // ----------------------------------------
    reg  [CHANS-1:0]     ovr_act;
    reg  [CHANS-1:0]     ovr_act_d;

    // Enter at 90%, leave at 80%
    genvar g;
    generate
        for (g = 0; g < CHANS; g = g + 1) begin : g_ovr
            wire [RW-1:0]  rd;
            wire [RW+3:0]  rd10;
            wire [RW+3:0]  sp9;
            wire [RW+3:0]  sp8;

            assign rd   = reading_i[g*RW +: RW];
            assign rd10 = {1'b0, rd, 3'b000} + {3'b000, rd, 1'b0};
            assign sp8  = {1'b0, ovr_span[g], 3'b000};
            assign sp9  = sp8 + {4'b0000, ovr_span[g]};

            always @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    ovr_act[g] <= 1'b0;
                end else if (!ovr_en[g]) begin
                    ovr_act[g] <= 1'b0;
                end else if (!ovr_act[g] && rd10 >= sp9) begin
                    ovr_act[g] <= 1'b1;
                end else if (ovr_act[g] && rd10 <= sp8) begin
                    ovr_act[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign over_range_o = ovr_act;

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ovr_act_d <= {CHANS{1'b0}};
        end else begin
            ovr_act_d <= ovr_act;
        end
    end

    // ----------------------------------------
    // Condition vector
    // ----------------------------------------
    reg  [31:0]          cond;

    always @* begin
        cond = 32'h0000_0000;
        // Fault conditions, lamp codes stay false
        cond[1]  = fault_i[0];
        cond[2]  = fault_i[1];
        cond[3]  = fault_i[2];
        cond[4]  = fault_i[3];
        cond[6]  = fault_i[4];
        cond[7]  = fault_i[5];
        cond[8]  = fault_i[6];
        cond[9]  = fault_i[7];
        cond[11] = fault_i[8];
        cond[12] = fault_i[9];
        cond[`COND_USB] = ~usb_present_i;
        cond[`COND_BACKGND] = background_active_i;
        cond[`COND_SPAN] = (cal_state_o == `CAL_SPAN);
        cond[`COND_ZERO] = (cal_state_o == `CAL_ZERO);
        cond[`COND_SYSFAULT] = |fault_i;
        cond[`COND_MAINT] = maint_mode;
        cond[`COND_OVR_LSB +: CHANS] = ovr_act;
        cond[`COND_DISABLED] = 1'b0;
    end

    assign cond_word = cond;

    // ----------------------------------------
    // Alarm outputs
    // ----------------------------------------
    // Registered so the pins never glitch while selections change.
    integer              n;

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            // Inactive level of the reset polarity, so no alarm shows in reset
            alarm_line_o <= {LINES{1'b1}};
        end else begin
            for (n = 0; n < LINES; n = n + 1) begin
                alarm_line_o[n] <= ~(cond[alarm_sel[n]] ^ alarm_pol[n]);
            end
        end
    end

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    wire [4:0]           irq_evt;

    assign irq_evt = {ovr_act & ~ovr_act_d, zero_req, span_req};

    // A new event beats a clear landing in the same cycle.
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_stat <= 5'h00;
        end else if (clr_fire) begin
            irq_stat <= (irq_stat & ~pwdata_i[4:0]) | irq_evt;
        end else begin
            irq_stat <= irq_stat | irq_evt;
        end
    end

    assign irq_o = |(irq_stat & irq_en);

endmodule

`default_nettype wire

/* File: src/dio_map_regs.vh */
// Constants for the trigger/alarm event mapper: register map and codes.
// Assumes a 32-bit APB master and a 40 MHz system clock.
`ifndef DIO_MAP_REGS_VH
`define DIO_MAP_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TRIG_CFG_OFS   8'h00
`define ALARM_SEL0_OFS 8'h04
`define ALARM_SEL1_OFS 8'h08
`define ALARM_POL_OFS  8'h0c
`define CAL_MODE_OFS   8'h10
`define IRQ_STAT_OFS   8'h14
`define IRQ_CLR_OFS    8'h18
`define IRQ_EN_OFS     8'h1c
`define COND_OFS       8'h20
`define OVR_CFG_OFS    8'h24
`define OVR_SPAN0_OFS  8'h28
`define OVR_SPAN1_OFS  8'h2c
`define OVR_SPAN2_OFS  8'h30

// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define TRIG_POL_LSB   16
`define OVR_MAINT_BIT  3
`define ACT_DISABLED   2'h0
`define ACT_SPAN       2'h1
`define ACT_ZERO       2'h2
`define CAL_MEASURE    2'h0
`define CAL_SPAN       2'h1
`define CAL_ZERO       2'h2
`define IRQ_SPAN_BIT   0
`define IRQ_ZERO_BIT   1
`define IRQ_OVR_LSB    2

// Alarm condition codes
`define COND_DISABLED  5'h00
`define COND_FAULT_LSB 1
`define COND_USB       5'h0d
`define COND_BACKGND   5'h0e
`define COND_SPAN      5'h0f
`define COND_ZERO      5'h10
`define COND_SYSFAULT  5'h11
`define COND_MAINT     5'h12
`define COND_OVR_LSB   19

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TRIG_CFG_RST   32'h0000_0000
`define ALARM_SEL_RST  32'h0000_0000
`define ALARM_POL_RST  8'h00
`define OVR_SPAN_RST   16'hffff

`endif
